//--- rtl/sds_datapath.sv
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "sds_consts.svh"
// Notes on behaviour
// - Transmit and receive parallel words are both 16 bits wide.
// - Buffer reset low initialises the buffer; release fixes the input phase.
// - Buffer starts half full, absorbing input drift either way.
// - Buffer reset acts asynchronously, needing no clock edge.
// - Buffer error goes high on buffer underflow or overflow.
// - Error clears by buffer reset or automatically within nine clocks.
// - While the buffer is being reset the transmit word is 1010.
// - Normal timing clocks the transmit shifter from the reference times 16.
// - Serializer sends bit 15 first, then lower bits in descending order.
// - Serial output takes transmit shifter or receive loopback data.
// - Line fault falls at once on input fall, else moves on reference ticks.
// - Out-of-range recovered data makes recovery track the reference.
// - First received bit of each word lands in receive bit 15.
// - Facility loop retimes receive data out and still deserializes it.
// - Equipment loop feeds transmit serial data to recovery, ignoring detect.
// - Analog loop buffers receive data out without retiming.
// - Analog loop only when facility loop off; with neither loop, transmit shifter data.
// - Loop timing clocks the transmit shifter from the recovered clock.
// - General reset clears all but the buffer; buffer reset clears the buffer.
// - Power down drives serial out low, stops receive words and holds the buffer in reset.
// - Signal detect low makes recovery lock to the reference, except in equipment loop.
module sds_datapath
    import sds_pkg::*;
#(
    parameter int DEPTH = `SDS_FIFO_DEPTH
)(
    input  wire logic                      mclk,
    input  wire logic                      rst_b,
    input  wire logic                      txBufRst_b,
    input  wire logic [`SDS_WORD_W-1:0]    txData,
    input  wire logic                      txWordValid,
    input  wire logic                      serialIn,
    input  wire logic                      signalDetect,
    input  wire logic                      forceRefLockN,
    output logic                           serialOut,
    output logic                           txClockOut,
    output logic [`SDS_WORD_W-1:0]         rxData,
    output logic                           rxWordValid,
    output logic                           rxWordClock,
    output logic                           txBufErr,
    output logic                           lineFaultN,
    input  wire logic [`SDS_ADDR_W-1:0]    awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    input  wire logic [`SDS_ADDR_W-1:0]    araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [AW-1:0] HALF_P = AW'(DEPTH / 2);
    localparam logic [CW-1:0] HALF_C = CW'(DEPTH / 2);
    localparam logic [CW-1:0] FULL_C = CW'(DEPTH);

    sds_ctrl_t              ctrl_r;
    logic [`SDS_WORD_W-1:0] mem [DEPTH];
    logic [AW-1:0]          wp_r, rp_r;
    logic [CW-1:0]          cnt_r;
    logic [3:0]             clrCnt_r;
    logic                   bufRstS1_r, bufRstS2_r;
    logic                   rxS1_r, rxS2_r, rxRet_r;
    logic                   sdS1_r, sdS2_r, lockS1_r, lockS2_r;
    logic [3:0]             refCnt_r, rxCnt_r;
    logic [`SDS_WORD_W-1:0] txShift_r, rxShift_r;
    logic [6:0]             idleRun_r;
    logic                   prevBit_r;
    logic [`SDS_ADDR_W-1:0] awAddr_r;
    logic [31:0]            wData_r;
    logic                   wLane_r, awHeld_r, wHeld_r;
    logic                   initActive, load, rdEn, wrOk, overflow, underflow;
    logic                   cdrIn, freqOk, cdrOnData, lineOk, faultArst_b;
    logic [3:0]             txPhase;

    function automatic logic [1:0] respFor(input logic [`SDS_ADDR_W-1:0] a);
        return (a == `SDS_OFF_CTRL || a == `SDS_OFF_STAT) ? `SDS_RESP_OKAY : `SDS_RESP_SLVERR;
    endfunction

    // ==========================================================
    // Clocks: reference word phase and transmit phase source
    assign txPhase = ctrl_r.loopTimed ? rxCnt_r : refCnt_r;
    assign load    = (txPhase == `SDS_PHASE_LAST);

    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            refCnt_r <= 4'h0;
        else
            refCnt_r <= refCnt_r + 4'h1;

    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            txClockOut <= 1'b0;
        else
            txClockOut <= txPhase[3];

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
        begin
            {rxS1_r, rxS2_r, sdS1_r, sdS2_r, lockS1_r, lockS2_r} <= 6'h00;
        end
        else
        begin
            rxS1_r   <= serialIn;
            rxS2_r   <= rxS1_r;
            sdS1_r   <= signalDetect;
            sdS2_r   <= sdS1_r;
            lockS1_r <= forceRefLockN;
            lockS2_r <= lockS1_r;
        end

    // Assert at once, release through two flops so pointers leave reset cleanly
    always_ff @(posedge mclk or negedge txBufRst_b)
        if (!txBufRst_b)
        begin
            bufRstS1_r <= 1'b0;
            bufRstS2_r <= 1'b0;
        end
        else
        begin
            bufRstS1_r <= 1'b1;
            bufRstS2_r <= bufRstS1_r;
        end

    // ==========================================================
    // Phase-align buffer
    assign initActive = !bufRstS2_r || !ctrl_r.powerDownN;
    assign rdEn       = load && !initActive && !txBufErr;
    assign overflow   = txWordValid && cnt_r == FULL_C && !rdEn;
    assign underflow  = rdEn && cnt_r == '0;
    assign wrOk       = txWordValid && !initActive && !txBufErr && !overflow && !underflow;

    // Half-full start gives DEPTH/2 words of slack for drift either way
    always_ff @(posedge mclk or negedge txBufRst_b)
        if (!txBufRst_b)
        begin
            wp_r     <= HALF_P;
            rp_r     <= '0;
            cnt_r    <= HALF_C;
            txBufErr <= 1'b0;
            clrCnt_r <= 4'h0;
        end
        else if (initActive)
        begin
            wp_r     <= HALF_P;
            rp_r     <= '0;
            cnt_r    <= HALF_C;
            txBufErr <= 1'b0;
            clrCnt_r <= 4'h0;
        end
        else if (txBufErr)
        begin
            if (clrCnt_r == `SDS_AUTOCLR_CYC - 4'h1)
            begin
                wp_r     <= HALF_P;
                rp_r     <= '0;
                cnt_r    <= HALF_C;
                txBufErr <= 1'b0;
                clrCnt_r <= 4'h0;
            end
            else
                clrCnt_r <= clrCnt_r + 4'h1;
        end
        else if (overflow || underflow)
            txBufErr <= 1'b1;
        else
        begin
            if (wrOk)
                wp_r <= wp_r + AW'(1);
            if (rdEn)
                rp_r <= rp_r + AW'(1);
            if (wrOk && !rdEn)
                cnt_r <= cnt_r + CW'(1);
            else if (rdEn && !wrOk)
                cnt_r <= cnt_r - CW'(1);
        end

    // Stale words read after a buffer reset are idle words, never unknowns
    always_ff @(posedge mclk or negedge txBufRst_b)
        if (!txBufRst_b)
            mem <= '{default: `SDS_IDLE_WORD};
        else if (wrOk)
            mem[wp_r] <= txData;

    // ==========================================================
    // Serializer
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            txShift_r <= `SDS_IDLE_WORD;
        else if (load)
            txShift_r <= rdEn ? mem[rp_r] : `SDS_IDLE_WORD;
        else
            txShift_r <= {txShift_r[`SDS_WORD_W-2:0], 1'b0};

    // ==========================================================
    // Clock recovery and deserializer
    assign cdrIn     = ctrl_r.equipLoop ? txShift_r[`SDS_WORD_W-1] : rxS2_r;
    assign freqOk    = idleRun_r < `SDS_DEAD_BITS;
    assign lineOk    = (sdS2_r || ctrl_r.equipLoop) && lockS2_r;
    assign cdrOnData = freqOk && lineOk;

    // A long run without transitions stands for an out-of-range stream
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
        begin
            idleRun_r <= 7'h00;
            prevBit_r <= 1'b0;
        end
        else
        begin
            prevBit_r <= cdrIn;
            if (cdrIn != prevBit_r)
                idleRun_r <= 7'h00;
            else if (freqOk)
                idleRun_r <= idleRun_r + 7'h01;
        end

    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            rxCnt_r <= 4'h0;
        else if (!cdrOnData)
            rxCnt_r <= refCnt_r + 4'h1;
        else
            rxCnt_r <= rxCnt_r + 4'h1;

    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
        begin
            rxShift_r   <= '0;
            rxData      <= '0;
            rxWordValid <= 1'b0;
            rxWordClock <= 1'b0;
        end
        else
        begin
            rxShift_r   <= {rxShift_r[`SDS_WORD_W-2:0], cdrIn};
            rxWordValid <= ctrl_r.powerDownN && rxCnt_r == `SDS_PHASE_LAST;
            rxWordClock <= rxCnt_r[3];
            if (rxCnt_r == `SDS_PHASE_LAST)
                rxData <= {rxShift_r[`SDS_WORD_W-2:0], cdrIn};
        end

    // ==========================================================
    // Serial output driver
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
        begin
            rxRet_r   <= 1'b0;
            serialOut <= 1'b0;
        end
        else
        begin
            rxRet_r <= rxS2_r;
            if (!ctrl_r.powerDownN)
                serialOut <= 1'b0;
            else if (ctrl_r.facilityLoop)
                serialOut <= rxRet_r;
            else if (ctrl_r.analogLoop)
                serialOut <= rxS2_r;
            else
                serialOut <= txShift_r[`SDS_WORD_W-1];
        end

    // ==========================================================
    // Line fault: falls at once on the raw pins, recovers on reference ticks
    assign faultArst_b = rst_b && (signalDetect || ctrl_r.equipLoop) && forceRefLockN;

    always_ff @(posedge mclk or negedge faultArst_b)
        if (!faultArst_b)
            lineFaultN <= 1'b0;
        else if (refCnt_r == `SDS_PHASE_LAST)
            lineFaultN <= lineOk;

    // ==========================================================
    // AXI4-Lite write channel and control register
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
        begin
            awready  <= 1'b1;
            wready   <= 1'b1;
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            awAddr_r <= '0;
            wData_r  <= '0;
            wLane_r  <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= `SDS_RESP_OKAY;
            ctrl_r   <= `SDS_CTRL_RST;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awAddr_r <= awaddr;
                awHeld_r <= 1'b1;
                awready  <= 1'b0;
            end
            if (wvalid && wready)
            begin
                wData_r <= wdata;
                wLane_r <= wstrb[0];
                wHeld_r <= 1'b1;
                wready  <= 1'b0;
            end
            if (awHeld_r && wHeld_r && !bvalid)
            begin
                if (awAddr_r == `SDS_OFF_CTRL && wLane_r)
                    ctrl_r <= wData_r[`SDS_CTRL_W-1:0];
                bresp    <= respFor(awAddr_r);
                bvalid   <= 1'b1;
                awHeld_r <= 1'b0;
                wHeld_r  <= 1'b0;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end

    // ==========================================================
    // AXI4-Lite read channel
    sds_stat_t stat;
    assign stat = '{bufInit: initActive, cdrOnData: cdrOnData, lineFaultN: lineFaultN, bufErr: txBufErr};

    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `SDS_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= respFor(araddr);
            if (araddr == `SDS_OFF_CTRL)
                rdata <= {27'h0, ctrl_r};
            else if (araddr == `SDS_OFF_STAT)
                rdata <= {28'h0000000, stat};
            else
                rdata <= 32'h00000000;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end

    // ==========================================================
    // Assertions
    property p_err_on_fault;
        @(posedge mclk) disable iff (!rst_b || !txBufRst_b)
        (!initActive && !txBufErr && (overflow || underflow)) |=> txBufErr;
    endproperty
    a_err_on_fault: assert property (p_err_on_fault) else $error("buffer fault not flagged");

    property p_err_autoclear;
        @(posedge mclk) disable iff (!rst_b || !txBufRst_b)
        $rose(txBufErr) |-> ##[1:9] !txBufErr;
    endproperty
    a_err_autoclear: assert property (p_err_autoclear) else $error("buffer error not cleared in time");

    property p_idle_pattern;
        @(posedge mclk) disable iff (!rst_b)
        (load && initActive) |=> txShift_r == `SDS_IDLE_WORD;
    endproperty
    a_idle_pattern: assert property (p_idle_pattern) else $error("idle word missing in buffer reset");

    property p_tx_msb_first;
        @(posedge mclk) disable iff (!rst_b)
        (load && rdEn) ##1 (ctrl_r.powerDownN && !ctrl_r.facilityLoop && !ctrl_r.analogLoop)
        |=> serialOut == $past(mem[rp_r][`SDS_WORD_W-1], 2);
    endproperty
    a_tx_msb_first: assert property (p_tx_msb_first) else $error("serial word not msb first");

    property p_fault_tick;
        @(posedge mclk) disable iff (!rst_b)
        (refCnt_r == `SDS_PHASE_LAST && !lineOk) |=> !lineFaultN;
    endproperty
    a_fault_tick: assert property (p_fault_tick) else $error("line fault not shown");

    property p_rx_msb;
        @(posedge mclk) disable iff (!rst_b)
        (rxCnt_r == `SDS_PHASE_LAST) |=> rxData[`SDS_WORD_W-1] == $past(cdrIn, 16);
    endproperty
    a_rx_msb: assert property (p_rx_msb) else $error("first bit not in bit 15");

    property p_facility_out;
        @(posedge mclk) disable iff (!rst_b)
        (ctrl_r.powerDownN && ctrl_r.facilityLoop) |=> serialOut == $past(rxS2_r, 2);
    endproperty
    a_facility_out: assert property (p_facility_out) else $error("facility loop data wrong");

    property p_analog_out;
        @(posedge mclk) disable iff (!rst_b)
        (ctrl_r.powerDownN && !ctrl_r.facilityLoop && ctrl_r.analogLoop) |=> serialOut == $past(rxS2_r);
    endproperty
    a_analog_out: assert property (p_analog_out) else $error("analog loop data wrong");

    property p_power_down;
        @(posedge mclk) disable iff (!rst_b)
        !ctrl_r.powerDownN |=> (!serialOut && !rxWordValid);
    endproperty
    a_power_down: assert property (p_power_down) else $error("driver active in power down");

    property p_word_rate;
        @(posedge mclk) disable iff (!rst_b)
        (rxWordValid && cdrOnData && $past(cdrOnData)) |=> !rxWordValid [*8];
    endproperty
    a_word_rate: assert property (p_word_rate) else $error("receive words too close");

    c_err_seen:   cover property (@(posedge mclk) disable iff (!rst_b) $rose(txBufErr));
    c_facility:   cover property (@(posedge mclk) disable iff (!rst_b) ctrl_r.facilityLoop && rxWordValid);
    c_equip_word: cover property (@(posedge mclk) disable iff (!rst_b) ctrl_r.equipLoop && rxWordValid);
    c_fault_drop: cover property (@(posedge mclk) disable iff (!rst_b) $fell(lineFaultN));

endmodule // sds_datapath

//--- shared/sds_consts.svh
// ==========================================================
// Constants of the serdes datapath
`ifndef SDS_CONSTS_SVH
`define SDS_CONSTS_SVH
`define SDS_WORD_W       16
`define SDS_FIFO_DEPTH   4
`define SDS_AUTOCLR_CYC  4'h9
`define SDS_IDLE_WORD    16'hAAAA
`define SDS_DEAD_BITS    7'h40
`define SDS_PHASE_LAST   4'hF
`define SDS_ADDR_W       4
`define SDS_OFF_CTRL     4'h0
`define SDS_OFF_STAT     4'h4
`define SDS_CTRL_W       5
`define SDS_CTRL_RST     5'h10
`define SDS_STAT_W       4
`define SDS_RESP_OKAY    2'h0
`define SDS_RESP_SLVERR  2'h2
`endif

//--- shared/sds_pkg.sv
// ==========================================================
// Types of the serdes datapath
`include "sds_consts.svh"
package sds_pkg;
    // Control register, bit 4 down to bit 0
    typedef struct packed {
        logic powerDownN;
        logic loopTimed;
        logic analogLoop;
        logic equipLoop;
        logic facilityLoop;
    } sds_ctrl_t;

    // Status register, bit 3 down to bit 0
    typedef struct packed {
        logic bufInit;
        logic cdrOnData;
        logic lineFaultN;
        logic bufErr;
    } sds_stat_t;
endpackage

//--- sim/sds_optic_model.sv
`timescale 1ns/1ns
// ==========================================================
// Optical module: repeats its word MSB first and records the line
module sds_optic_model
    import sds_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        lightOn,
    input  wire logic [15:0] word,
    input  wire logic        serialOut,
    output logic             serialIn,
    output logic             signalDetect,
    output logic [31:0]      hist
);
    logic [3:0]  bitCnt_r = 4'h0;
    logic        sIn_r    = 1'b0;
    logic [31:0] hist_r   = 32'h0;

    assign serialIn     = sIn_r;
    assign signalDetect = lightOn;
    assign hist         = hist_r;

    always_ff @(posedge mclk)
    begin
        bitCnt_r <= bitCnt_r + 4'h1;
        // No light means noise, so a stale level never passes for data
        sIn_r    <= lightOn ? word[4'hF - bitCnt_r] : ~sIn_r;
        hist_r   <= {hist_r[30:0], serialOut};
    end
endmodule // sds_optic_model

//--- sim/tb_top.sv
`timescale 1ns/1ns
`include "sds_consts.svh"
module tb_top
    import sds_pkg::*;
;
    logic        mclk = 1'b0, rst_b = 1'b0, txBufRst_b = 1'b0, feedOn = 1'b0;
    logic        lightOn = 1'b1, forceRefLockN = 1'b1, txWordValid = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        serialIn, signalDetect, serialOut, txClockOut, rxWordValid, rxWordClock;
    logic        txBufErr, lineFaultN, awready, wready, bvalid, arready, rvalid;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF, txCnt = 4'h0;
    logic [15:0] txData = 16'hD001, pWord = 16'h2C01, rxData;
    logic [31:0] wdata = 32'h0, rdata, hist, rd;
    logic [1:0]  bresp, rresp, rs;
    logic [4:0]  modes [6] = '{5'h10, 5'h11, 5'h14, 5'h15, 5'h12, 5'h18};
    int          n_mismatch = 0, n_compared = 0, cyc = 0, k, n;

    sds_datapath #(.DEPTH(`SDS_FIFO_DEPTH)) sds_datapath_inst (
        .mclk, .rst_b, .txBufRst_b, .txData, .txWordValid, .serialIn, .signalDetect,
        .forceRefLockN, .serialOut, .txClockOut, .rxData, .rxWordValid, .rxWordClock,
        .txBufErr, .lineFaultN, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);

    sds_optic_model sds_optic_model_inst (
        .mclk, .lightOn, .word(pWord), .serialOut, .serialIn, .signalDetect, .hist);

    // ==========================================================
    // Clock, framer word feed, watchdog
    always #10 mclk = ~mclk;

    always @(posedge mclk)
    begin
        txCnt       <= txCnt + 4'h1;
        txWordValid <= feedOn && (txCnt == 4'h0);
        cyc         <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            complete_run();
        end
    end

    // ==========================================================
    // Tasks
    task check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Stream check: some 16-bit window, newest bit lowest, must equal the word
    task check_word(input string nm, input logic [31:0] h, input logic [15:0] w);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i <= 16; i++)
            if (h[i +: 16] === w) hit = 1'b1;
        n_compared++;
        if (!hit)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, w, h);
        end
    endtask

    task tick(input int c);
        repeat (c) @(posedge mclk);
    endtask

    task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        r = bresp;
    endtask

    task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask

    task complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial
    begin
        tick(12);
        rst_b      <= 1'b1;
        txBufRst_b <= 1'b1;
        feedOn     <= 1'b1;
        @(posedge mclk);
        axi_rd(`SDS_OFF_CTRL, rd, rs);
        check_val("ctrl reset", 32'h10, rd);
        axi_rd(4'h8, rd, rs);
        check_val("unmapped resp", `SDS_RESP_SLVERR, rs);
        check_val("unmapped data", 32'h0, rd);
        axi_wr(`SDS_OFF_STAT, 32'hF, rs);
        check_val("stat write resp", `SDS_RESP_OKAY, rs);
        axi_wr(`SDS_OFF_CTRL, 32'hFFFFFFF1, rs);
        axi_rd(`SDS_OFF_CTRL, rd, rs);
        check_val("ctrl bits", 32'h11, rd);
        // Lane 0 strobe low: control must keep its value
        wstrb <= 4'h0;
        axi_wr(`SDS_OFF_CTRL, 32'h10, rs);
        wstrb <= 4'hF;
        axi_rd(`SDS_OFF_CTRL, rd, rs);
        check_val("ctrl lane", 32'h11, rd);
        // Second reset in mid-run brings control back
        rst_b <= 1'b0;
        @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        axi_rd(`SDS_OFF_CTRL, rd, rs);
        check_val("ctrl rereset", 32'h10, rd);
        // Output source and receive word for each loop mode
        for (k = 0; k < 6; k++)
        begin
            axi_wr(`SDS_OFF_CTRL, {27'h0, modes[k]}, rs);
            tick(120);
            check_word("serial out", hist, (modes[k][0] | modes[k][2]) ? pWord : txData);
            check_word("rx word", {rxData, rxData}, modes[k][1] ? txData : pWord);
        end
        for (k = 0; k < 40 && rxWordValid !== 1'b1; k++) @(posedge mclk);
        @(posedge mclk);
        for (k = 1; k < 40 && rxWordValid !== 1'b1; k++) @(posedge mclk);
        check_val("rx word spacing", 32'd16, k);
        // Both word clocks run at half duty over two word periods
        n = 0;
        repeat (32)
        begin
            @(posedge mclk);
            if (txClockOut === 1'b1) n++;
            if (rxWordClock === 1'b1) n++;
        end
        check_val("word clocks", 32'd32, n);
        // Equipment loop ignores signal detect
        axi_wr(`SDS_OFF_CTRL, 32'h12, rs);
        lightOn <= 1'b0;
        tick(40);
        check_val("fault in equip loop", 32'h1, lineFaultN);
        axi_wr(`SDS_OFF_CTRL, 32'h10, rs);
        lightOn <= 1'b1;
        tick(64);
        // Fault falls with no clock edge, clears on a reference tick
        for (k = 0; k < 2; k++)
        begin
            if (k == 0) lightOn <= 1'b0;
            else forceRefLockN <= 1'b0;
            #1;
            check_val("fault fall", 32'h0, lineFaultN);
            @(posedge mclk);
            tick(20);
            check_val("fault held", 32'h0, lineFaultN);
            axi_rd(`SDS_OFF_STAT, rd, rs);
            check_val("on reference", 32'h0, rd & 32'h6);
            lightOn       <= 1'b1;
            forceRefLockN <= 1'b1;
            for (n = 0; n < 64 && lineFaultN !== 1'b1; n++) @(posedge mclk);
            check_val("fault clear", 32'h1, lineFaultN);
        end
        // A stream without transitions is out of range: recovery follows the reference
        pWord <= 16'h0000;
        tick(90);
        axi_rd(`SDS_OFF_STAT, rd, rs);
        check_val("off range", 32'h2, rd & 32'h6);
        pWord <= 16'h2C01;
        tick(20);
        axi_rd(`SDS_OFF_STAT, rd, rs);
        check_val("back on data", 32'h6, rd & 32'h6);
        // Starved buffer: error stands nine clocks, then clears itself
        feedOn <= 1'b0;
        for (k = 0; k < 200 && txBufErr !== 1'b1; k++) @(posedge mclk);
        for (n = 0; n < 40 && txBufErr === 1'b1; n++) @(posedge mclk);
        check_val("error length", 32'd9, n);
        for (k = 0; k < 200 && txBufErr !== 1'b1; k++) @(posedge mclk);
        txBufRst_b <= 1'b0;
        #1;
        check_val("error async clear", 32'h0, txBufErr);
        @(posedge mclk);
        tick(40);
        check_word("idle pattern", hist, 16'hAAAA);
        axi_rd(`SDS_OFF_STAT, rd, rs);
        check_val("init flag", 32'h8, rd & 32'h9);
        txBufRst_b <= 1'b1;
        feedOn     <= 1'b1;
        tick(100);
        check_val("no error", 32'h0, txBufErr);
        check_word("resumed", hist, txData);
        // Power down: quiet line and no receive words
        txBufRst_b <= 1'b0;
        axi_wr(`SDS_OFF_CTRL, 32'h0, rs);
        tick(40);
        check_val("power down line", 32'h0, hist);
        n = 0;
        repeat (32)
        begin
            @(posedge mclk);
            if (rxWordValid !== 1'b0) n++;
        end
        check_val("power down rx", 32'h0, n);
        complete_run();
    end
endmodule // tb_top
